// file: hw/asc_defines.svh
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

// Register indices; byte address is four times the index
`define ASC_IDX_STATUS 8'hf0
`define ASC_IDX_DATA 8'hf1
`define ASC_IDX_RATE 8'hf2
`define ASC_IDX_CTRL1 8'hf3
`define ASC_IDX_CTRL2 8'hf4
`define ASC_IDX_CTRL3 8'hff

`define ASC_RST_STATUS 8'hc0
`define ASC_RST_CTRL 8'h00
`define ASC_RST_RATE 8'h00
`define ASC_CTRL3_MASK 8'h40

// Status bits
`define ASC_SR_TX_BUFFER_EMPTY 7
`define ASC_SR_TC 6
`define ASC_SR_RX_FULL_FLAG 5
`define ASC_SR_IDLE 4
`define ASC_SR_OR 3
`define ASC_SR_NF 2
`define ASC_SR_FE 1
`define ASC_SR_PE 0

// Control one bits
`define ASC_C1_R8 7
`define ASC_C1_T8 6
`define ASC_C1_LOW_POWER_DISABLE 5
`define ASC_C1_M 4
`define ASC_C1_WAKE 3
`define ASC_C1_PCE 2
`define ASC_C1_PS 1
`define ASC_C1_PIE 0

// Control two bits
`define ASC_C2_TIE 7
`define ASC_C2_TX_DONE_IRQ_EN 6
`define ASC_C2_RIE 5
`define ASC_C2_LINE_QUIET_IRQ_EN 4
`define ASC_C2_TE 3
`define ASC_C2_RE 2
`define ASC_C2_RWU 1
`define ASC_C2_SBK 0

// Control three bits
`define ASC_C3_LIN 6

// Bit timing, sixteen ticks per bit
`define ASC_TICK_LAST 4'hf
`define ASC_VOTE_FIRST 4'h7
`define ASC_VOTE_LAST 4'h9
`define ASC_FRAME_BITS 4'ha
`define ASC_BRK_LIN 4'hd
`define ASC_IDLE_TICKS_8 8'ha0
`define ASC_IDLE_TICKS_9 8'hb0

`endif

// file: hw/asc_pkg.sv
package asc_pkg;

   typedef enum logic [1:0] {
      ASC_TX_IDLE = 2'b01,
      ASC_TX_SEND = 2'b10
   } asc_tx_state_t;

   typedef enum logic [1:0] {
      ASC_RX_HUNT = 2'b01,
      ASC_RX_DATA = 2'b10
   } asc_rx_state_t;

endpackage : asc_pkg

// file: hw/asc_serial.sv
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`include "asc_defines.svh"
// Overview of operation
// - Transmit-empty set on load, cleared by sequence
// - Complete flag set at frame end
// - Receive-full set on word, cleared
// - Idle set once per received word
// - Overrun keeps holding data
// - Noise flag rides with receive-full
// - Framing error; overrun alone wins
// - Parity error flag, status-then-data clear
// - Interrupt from each enabled condition
// - Receiver off clears receive flags except parity error
// - Transmitter off floats pin; preamble on toggle during a frame
// - Eight or nine data bits per frame
// - Ninth bits stored and sent
// - Parity at MSB, effective next byte
// - Even or odd parity, next byte
// - Low-power stop once both paths idle
// - Mute mode, idle or address wake
// - Break sent while set, or once
// - Break length ten to fourteen bits
module asc_serial (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_line,
   output logic tx_line,
   output logic tx_line_oe,
   output logic irq_req
);
   import asc_pkg::*;

   logic [7:0] status_r, ctrl1_r, ctrl2_r, ctrl3_r, rate_r, tx_holding_reg_r, rx_holding_reg_r;
   logic [7:0] status_nxt, ctrl1_nxt, ctrl2_nxt;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r, irq_r, tx_line_r, tx_oe_r;
   logic sr_armed_r, te_prev_r, sbk_prev_r, pre_pend_r, brk_pend_r, brk_seen_r;
   logic [7:0] tick_cnt_r;
   asc_tx_state_t tx_state_r;
   asc_rx_state_t rx_state_r;
   logic [13:0] tx_frame_r;
   logic [3:0] tx_left_r, tx_tck_r;
   logic [3:0] rx_tck_r, rx_bit_r;
   logic [8:0] rx_sh_r;
   logic [2:0] rx_vote_r;
   logic rx_noise_r, rx_m_r, rx_pce_r, rx_ps_r;
   logic [7:0] idle_cnt_r;
   logic idle_done_r, idle_arm_r;

   // Bus decode
   wire [7:0] idx = paddr[9:2];
   wire aligned = (paddr[1:0] == 2'b00);
   wire hit_sr = aligned && (idx == `ASC_IDX_STATUS);
   wire hit_dr = aligned && (idx == `ASC_IDX_DATA);
   wire hit_rate = aligned && (idx == `ASC_IDX_RATE);
   wire hit_c1 = aligned && (idx == `ASC_IDX_CTRL1);
   wire hit_c2 = aligned && (idx == `ASC_IDX_CTRL2);
   wire hit_c3 = aligned && (idx == `ASC_IDX_CTRL3);
   wire hit_any = hit_sr || hit_dr || hit_rate || hit_c1 || hit_c2 || hit_c3;
   wire setup = psel && !penable;
   wire acc = psel && penable && pready_r;
   wire wr = acc && pwrite && hit_any;
   wire sr_acc = acc && hit_sr;
   wire dr_rd = acc && !pwrite && hit_dr;
   wire dr_wr = wr && hit_dr;
   wire [7:0] c3_rd = ctrl3_r & `ASC_CTRL3_MASK;
   wire [7:0] rd_mux = hit_sr ? status_r :
                       hit_dr ? rx_holding_reg_r :
                       hit_rate ? rate_r :
                       hit_c1 ? ctrl1_r :
                       hit_c2 ? ctrl2_r :
                       hit_c3 ? c3_rd : 8'h00;

   // Control fields
   wire m_bit = ctrl1_r[`ASC_C1_M];
   wire te = ctrl2_r[`ASC_C2_TE];
   wire re = ctrl2_r[`ASC_C2_RE];
   wire mute = ctrl2_r[`ASC_C2_RWU];
   wire break_send = ctrl2_r[`ASC_C2_SBK];
   wire lin = ctrl3_r[`ASC_C3_LIN];
   wire tx_buffer_empty = status_r[`ASC_SR_TX_BUFFER_EMPTY];
   wire rx_full_flag = status_r[`ASC_SR_RX_FULL_FLAG];

   // Baud tick; shared by both paths
   wire tx_busy = (tx_state_r == ASC_TX_SEND);
   wire rx_busy = (rx_state_r == ASC_RX_DATA);
   // stop prescaler once both paths idle
   wire stopped = ctrl1_r[`ASC_C1_LOW_POWER_DISABLE] && !tx_busy && !rx_busy;
   wire tick = !stopped && (tick_cnt_r == rate_r);

   // Transmit path
   wire tx_bit_end = tx_busy && tick && (tx_tck_r == `ASC_TICK_LAST);
   wire tx_last = tx_bit_end && (tx_left_r == 4'h1);
   wire tx_can_load = te && !stopped && (!tx_busy || tx_last);
   // held bit or pending single break
   wire load_brk = tx_can_load && (break_send || brk_pend_r);
   wire load_pre = tx_can_load && !load_brk && pre_pend_r;
   // data waits until holding register is filled
   wire load_dat = tx_can_load && !load_brk && !load_pre && !tx_buffer_empty;
   wire tx_load = load_brk || load_pre || load_dat;
   // parity taken from current settings at load
   wire [7:0] par_src = m_bit ? tx_holding_reg_r : {1'b0, tx_holding_reg_r[6:0]};
   wire tx_par = (^par_src) ^ ctrl1_r[`ASC_C1_PS];
   wire parity_ctrl_en = ctrl1_r[`ASC_C1_PCE];
   wire tx_ninth = parity_ctrl_en ? tx_par : ctrl1_r[`ASC_C1_T8];
   wire tx_b7 = parity_ctrl_en ? tx_par : tx_holding_reg_r[7];
   // frame of start, 8 or 9 data, stop
   wire [13:0] dat_frame = m_bit ? {4'hf, tx_ninth, tx_holding_reg_r, 1'b0}
                                 : {5'h1f, tx_b7, tx_holding_reg_r[6:0], 1'b0};
   wire [3:0] frame_len = `ASC_FRAME_BITS + {3'b000, m_bit};
   wire [3:0] brk_len = (lin ? `ASC_BRK_LIN : `ASC_FRAME_BITS) + {3'b000, m_bit};
   wire [13:0] load_frame = load_brk ? 14'h0000 : load_pre ? 14'h3fff : dat_frame;
   wire [3:0] load_len = load_brk ? brk_len : frame_len;

   // Receive path
   wire rx_tick_end = rx_busy && tick && (rx_tck_r == `ASC_TICK_LAST);
   wire vote = (rx_vote_r[0] & rx_vote_r[1]) | (rx_vote_r[0] & rx_vote_r[2]) | (rx_vote_r[1] & rx_vote_r[2]);
   wire vote_noisy = !(&rx_vote_r) && (|rx_vote_r);
   wire [3:0] rx_nd = rx_m_r ? 4'h9 : 4'h8;
   wire rx_false_start = rx_tick_end && (rx_bit_r == 4'h0) && vote;
   wire rx_done = rx_tick_end && (rx_bit_r == rx_nd + 4'h1);
   wire rx_start = re && !rx_busy && tick && !rx_line;
   wire [7:0] rx_byte = rx_m_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
   wire rx_msb = rx_sh_r[8];
   wire [8:0] par_chk = rx_m_r ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
   wire rx_par_bad = rx_pce_r && ((^par_chk) != rx_ps_r);
   wire wake_addr = mute && ctrl1_r[`ASC_C1_WAKE] && rx_msb;
   // muted words are dropped unless address mark
   wire rx_accept = rx_done && (!mute || wake_addr);
   wire [7:0] idle_lim = m_bit ? `ASC_IDLE_TICKS_9 : `ASC_IDLE_TICKS_8;
   wire idle_det = re && !rx_busy && tick && rx_line && !idle_done_r && (idle_cnt_r == idle_lim);
   wire wake_idle = idle_det && mute && !ctrl1_r[`ASC_C1_WAKE];

   // Status next value; sets override sequence clears, receiver off clears last
   always_comb
   begin
      status_nxt = status_r;
      if (dr_wr && sr_armed_r)
      begin
         status_nxt[`ASC_SR_TX_BUFFER_EMPTY] = 1'b0;
         status_nxt[`ASC_SR_TC] = 1'b0;
      end
      if (dr_rd && sr_armed_r)
      begin
         status_nxt[5:0] = 6'h00;
      end
      // set when data moves to shifter
      if (load_dat)
      begin
         status_nxt[`ASC_SR_TX_BUFFER_EMPTY] = 1'b1;
      end
      // set at end of any frame
      if (tx_last)
      begin
         status_nxt[`ASC_SR_TC] = 1'b1;
      end
      // once per word, never on mute wake
      if (idle_det && idle_arm_r && !mute)
      begin
         status_nxt[`ASC_SR_IDLE] = 1'b1;
      end
      if (rx_accept)
      begin
         if (rx_full_flag)
         begin
            status_nxt[`ASC_SR_OR] = 1'b1;
         end
         else
         begin
            status_nxt[`ASC_SR_RX_FULL_FLAG] = 1'b1;
            status_nxt[`ASC_SR_NF] = rx_noise_r;
            status_nxt[`ASC_SR_FE] = !vote;
            status_nxt[`ASC_SR_PE] = rx_par_bad;
         end
      end
      if (!re)
      begin
         status_nxt[5:1] = 5'h00;
      end
   end

   always_comb
   begin
      ctrl1_nxt = ctrl1_r;
      ctrl2_nxt = ctrl2_r;
      if (wr && hit_c1)
      begin
         ctrl1_nxt[6:0] = pwdata[6:0];
      end
      if (wr && hit_c2)
      begin
         ctrl2_nxt = pwdata[7:0];
      end
      if (rx_accept && !rx_full_flag)
      begin
         ctrl1_nxt[`ASC_C1_R8] = rx_sh_r[8];
      end
      if (wake_addr && rx_done || wake_idle)
      begin
         ctrl2_nxt[`ASC_C2_RWU] = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_r <= `ASC_RST_STATUS;
         ctrl1_r <= `ASC_RST_CTRL;
         ctrl2_r <= `ASC_RST_CTRL;
         ctrl3_r <= `ASC_RST_CTRL;
         rate_r <= `ASC_RST_RATE;
         tx_holding_reg_r <= 8'h00;
         rx_holding_reg_r <= 8'h00;
         sr_armed_r <= 1'b0;
      end
      else
      begin
         status_r <= status_nxt;
         ctrl1_r <= ctrl1_nxt;
         ctrl2_r <= ctrl2_nxt;
         if (wr && hit_c3)
         begin
            // only the mode bit is stored
            ctrl3_r <= pwdata[7:0] & `ASC_CTRL3_MASK;
         end
         if (wr && hit_rate)
         begin
            rate_r <= pwdata[7:0];
         end
         if (dr_wr)
         begin
            tx_holding_reg_r <= pwdata[7:0];
         end
         // holding register only loads when empty
         if (rx_accept && !rx_full_flag)
         begin
            rx_holding_reg_r <= rx_byte;
         end
         if (sr_acc)
         begin
            sr_armed_r <= 1'b1;
         end
         else if (dr_rd || dr_wr)
         begin
            sr_armed_r <= 1'b0;
         end
      end
   end

   // Bus answer; zero wait states
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         pready_r <= setup;
         if (setup)
         begin
            prdata_r <= {24'h00_0000, rd_mux};
            pslverr_r <= !hit_any;
         end
         irq_r <= (ctrl2_r[`ASC_C2_TIE] && tx_buffer_empty) || (ctrl2_r[`ASC_C2_TX_DONE_IRQ_EN] && status_r[`ASC_SR_TC]) ||
                  (ctrl2_r[`ASC_C2_RIE] && (rx_full_flag || status_r[`ASC_SR_OR])) ||
                  (ctrl2_r[`ASC_C2_LINE_QUIET_IRQ_EN] && status_r[`ASC_SR_IDLE]) ||
                  (ctrl1_r[`ASC_C1_PIE] && status_r[`ASC_SR_PE]);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_cnt_r <= 8'h00;
      end
      else if (stopped || tick)
      begin
         tick_cnt_r <= 8'h00;
      end
      else
      begin
         tick_cnt_r <= tick_cnt_r + 8'h01;
      end
   end

   // Transmitter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_state_r <= ASC_TX_IDLE;
         tx_frame_r <= 14'h3fff;
         tx_left_r <= 4'h0;
         tx_tck_r <= 4'h0;
         te_prev_r <= 1'b0;
         sbk_prev_r <= 1'b0;
         pre_pend_r <= 1'b0;
         brk_pend_r <= 1'b0;
         brk_seen_r <= 1'b0;
         tx_line_r <= 1'b1;
         tx_oe_r <= 1'b0;
      end
      else
      begin
         te_prev_r <= te;
         sbk_prev_r <= break_send;
         if (te && !te_prev_r && tx_busy)
         begin
            pre_pend_r <= 1'b1;
         end
         else if (load_pre)
         begin
            pre_pend_r <= 1'b0;
         end
         // a set-then-clear leaves one break pending
         // Not when one already left while set, else two words
         if (sbk_prev_r && !break_send && !brk_seen_r)
         begin
            brk_pend_r <= 1'b1;
         end
         else if (load_brk)
         begin
            brk_pend_r <= 1'b0;
         end
         if (break_send && load_brk)
         begin
            brk_seen_r <= 1'b1;
         end
         else if (!break_send)
         begin
            brk_seen_r <= 1'b0;
         end
         unique case (tx_state_r)
            ASC_TX_IDLE:
            begin
               if (tx_load)
               begin
                  tx_state_r <= ASC_TX_SEND;
                  tx_frame_r <= load_frame;
                  tx_left_r <= load_len;
                  tx_tck_r <= 4'h0;
               end
            end
            ASC_TX_SEND:
            begin
               if (tick)
               begin
                  tx_tck_r <= tx_tck_r + 4'h1;
               end
               if (tx_last && tx_load)
               begin
                  tx_frame_r <= load_frame;
                  tx_left_r <= load_len;
               end
               else if (tx_last)
               begin
                  tx_state_r <= ASC_TX_IDLE;
                  tx_frame_r <= 14'h3fff;
               end
               else if (tx_bit_end)
               begin
                  tx_frame_r <= {1'b1, tx_frame_r[13:1]};
                  tx_left_r <= tx_left_r - 4'h1;
               end
            end
         endcase
         tx_line_r <= tx_busy ? tx_frame_r[0] : 1'b1;
         tx_oe_r <= te && !stopped;
      end
   end

   // Receiver
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_state_r <= ASC_RX_HUNT;
         rx_tck_r <= 4'h0;
         rx_bit_r <= 4'h0;
         rx_sh_r <= 9'h000;
         rx_vote_r <= 3'b111;
         rx_noise_r <= 1'b0;
         rx_m_r <= 1'b0;
         rx_pce_r <= 1'b0;
         rx_ps_r <= 1'b0;
         idle_cnt_r <= 8'h00;
         idle_done_r <= 1'b0;
         idle_arm_r <= 1'b1;
      end
      else
      begin
         // rearm only after a new word
         if (status_nxt[`ASC_SR_RX_FULL_FLAG] && !rx_full_flag)
         begin
            idle_arm_r <= 1'b1;
         end
         else if (idle_det)
         begin
            idle_arm_r <= 1'b0;
         end
         if (!re || rx_busy || !rx_line)
         begin
            idle_cnt_r <= 8'h00;
            idle_done_r <= 1'b0;
         end
         else if (idle_det)
         begin
            idle_done_r <= 1'b1;
         end
         else if (tick && !idle_done_r)
         begin
            idle_cnt_r <= idle_cnt_r + 8'h01;
         end
         unique case (rx_state_r)
            ASC_RX_HUNT:
            begin
               if (rx_start)
               begin
                  rx_state_r <= ASC_RX_DATA;
                  rx_tck_r <= 4'h1;
                  rx_bit_r <= 4'h0;
                  rx_noise_r <= 1'b0;
                  // settings held for the whole frame
                  rx_m_r <= m_bit;
                  rx_pce_r <= parity_ctrl_en;
                  rx_ps_r <= ctrl1_r[`ASC_C1_PS];
               end
            end
            ASC_RX_DATA:
            begin
               if (!re || rx_false_start || rx_done)
               begin
                  rx_state_r <= ASC_RX_HUNT;
               end
               if (tick)
               begin
                  rx_tck_r <= rx_tck_r + 4'h1;
                  if (rx_tck_r >= `ASC_VOTE_FIRST && rx_tck_r <= `ASC_VOTE_LAST)
                  begin
                     rx_vote_r <= {rx_vote_r[1:0], rx_line};
                  end
               end
               if (rx_tick_end)
               begin
                  rx_bit_r <= rx_bit_r + 4'h1;
                  rx_noise_r <= rx_noise_r || vote_noisy;
                  // data bits shift in LSB first
                  if (rx_bit_r != 4'h0 && rx_bit_r <= rx_nd)
                  begin
                     rx_sh_r <= {vote, rx_sh_r[8:1]};
                  end
               end
            end
         endcase
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign tx_line = tx_line_r;
   assign tx_line_oe = tx_oe_r;
   assign irq_req = irq_r;

   sequence seq_last_bit;
      tx_last && !tx_load;
   endsequence

   AST_TX_BUFFER_EMPTY_SET: assert property (@(posedge pclk) disable iff (!presetn) load_dat |=> tx_buffer_empty && tx_busy)
      else $error("transmit empty not set on load");
   AST_TC_SET: assert property (@(posedge pclk) disable iff (!presetn)
      seq_last_bit |=> status_r[`ASC_SR_TC] && !tx_busy ##1 tx_line_r)
      else $error("complete flag missing at frame end");
   AST_RXOFF: assert property (@(posedge pclk) disable iff (!presetn)
      !re |=> !status_r[`ASC_SR_RX_FULL_FLAG] && !status_r[`ASC_SR_OR] && !status_r[`ASC_SR_FE])
      else $error("receive flags survive receiver off");
   AST_OVR_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
      rx_accept && rx_full_flag && re |=> status_r[`ASC_SR_OR] && $stable(rx_holding_reg_r))
      else $error("overrun lost holding data");
   AST_IRQ_TX: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl2_r[`ASC_C2_TIE] && tx_buffer_empty)[*2] |-> irq_req)
      else $error("enabled transmit empty gives no request");
   AST_TX_FLOAT: assert property (@(posedge pclk) disable iff (!presetn) !te |=> !tx_line_oe)
      else $error("pin driven while transmitter off");
   AST_BRK_LEN: assert property (@(posedge pclk) disable iff (!presetn)
      load_brk |=> tx_left_r == $past(brk_len) && tx_frame_r == 14'h0000)
      else $error("break length wrong");
   AST_MUTE_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      wake_idle && !status_r[`ASC_SR_IDLE] |=> !mute && !status_r[`ASC_SR_IDLE])
      else $error("idle wake did not end mute cleanly");

endmodule : asc_serial

// file: tb/asc_remote_node.sv
`timescale 1ns/100ps
module asc_remote_node #(
   parameter int BIT_CYC = 16
)(
   input wire logic pclk,
   input wire logic tx_line,
   input wire logic tx_line_oe,
   output logic rx_line
);
   logic [9:0] got_word;
   int low_run = 0;
   int last_low = 0;
   initial rx_line = 1'b1;
   task automatic send_frame(input logic [8:0] w, input int nbits);
      rx_line <= 1'b0;
      repeat (BIT_CYC) @(posedge pclk);
      for (int i = 0; i < nbits; i++)
      begin
         rx_line <= w[i];
         repeat (BIT_CYC) @(posedge pclk);
      end
      rx_line <= 1'b1;
      repeat (BIT_CYC) @(posedge pclk);
   endtask : send_frame
   always
   begin
      @(negedge tx_line);
      if (tx_line_oe === 1'b1)
      begin
         repeat (BIT_CYC / 2) @(posedge pclk);
         for (int i = 0; i < 10; i++)
         begin
            got_word[i] = tx_line;
            repeat (BIT_CYC) @(posedge pclk);
         end
      end
   end
   always @(posedge pclk)
   begin
      if (tx_line === 1'b0)
         low_run <= low_run + 1;
      else if (low_run != 0)
      begin
         last_low <= low_run;
         low_run <= 0;
      end
   end
endmodule : asc_remote_node

// file: tb/async_serial_status_control_test.sv
`timescale 1ns/100ps
module async_serial_status_control_test;
   localparam logic [9:0] A_ST = 10'h3c0, A_DT = 10'h3c4, A_RT = 10'h3c8;
   localparam logic [9:0] A_C1 = 10'h3cc, A_C2 = 10'h3d0, A_C3 = 10'h3fc;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic rx_line, tx_line, tx_line_oe, irq_req, err;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] q;
   int num_errors = 0;
   int checked = 0;
   asc_serial uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_line(rx_line), .tx_line(tx_line), .tx_line_oe(tx_line_oe), .irq_req(irq_req));
   asc_remote_node node (.pclk(pclk), .tx_line(tx_line), .tx_line_oe(tx_line_oe), .rx_line(rx_line));
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic finish_test;
      if (num_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // One idle cycle after release, so no double drive
   task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
      apb(1'b0, a, 8'h00);
      chk(n, 10'(e), 10'(q & m));
   endtask : rd
   // Bounded at 300 reads; a flag that never rises fails the poll check
   task automatic poll(input int b);
      int k;
      k = 0;
      do
      begin
         apb(1'b0, A_ST, 8'h00);
         k++;
      end
      while (q[b] !== 1'b1 && k < 300);
      chk("poll", 10'h1, 10'(q[b]));
   endtask : poll
   initial
   begin
      repeat (50000) @(posedge pclk);
      num_errors++;
      finish_test();
   end
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(A_ST, 8'hff, 8'hc0, "status");
      rd(A_C2, 8'hff, 8'h00, "ctrl2");
      chk("oe", 10'h0, 10'(tx_line_oe));
      wr(A_C3, 8'hff);
      rd(A_C3, 8'hff, 8'h40, "ctrl3");
      rd(10'h000, 8'hff, 8'h00, "unmapped");
      chk("slverr", 10'h1, 10'(err));
      wr(A_RT, 8'h00);
      wr(A_C3, 8'h00);
      wr(A_C2, 8'h0c);
      rd(A_ST, 8'hc0, 8'hc0, "status");
      wr(A_DT, 8'h5a);
      rd(A_ST, 8'h40, 8'h00, "tc");
      poll(6);
      chk("tx word", 10'h2b4, node.got_word);
      node.send_frame(9'h0a5, 8);
      poll(5);
      rd(A_DT, 8'hff, 8'ha5, "rx data");
      rd(A_ST, 8'h2e, 8'h00, "status");
      poll(4);
      rd(A_DT, 8'hff, 8'ha5, "rx data");
      repeat (400) @(posedge pclk);
      rd(A_ST, 8'h10, 8'h00, "idle");
      node.send_frame(9'h011, 8);
      node.send_frame(9'h022, 9);
      wr(A_C2, 8'h2c);
      @(posedge pclk);
      chk("irq", 10'h1, 10'(irq_req));
      rd(A_ST, 8'h2a, 8'h28, "status");
      rd(A_DT, 8'hff, 8'h11, "rx data");
      node.send_frame(9'h033, 9);
      rd(A_ST, 8'h22, 8'h22, "status");
      wr(A_C2, 8'h08);
      rd(A_ST, 8'h3e, 8'h00, "status");
      wr(A_C1, 8'h05);
      wr(A_C2, 8'h0c);
      node.send_frame(9'h001, 8);
      poll(5);
      rd(A_ST, 8'h01, 8'h01, "parity");
      @(posedge pclk);
      chk("irq", 10'h1, 10'(irq_req));
      rd(A_DT, 8'hff, 8'h01, "rx data");
      for (int ps = 0; ps < 2; ps++)
      begin
         wr(A_C1, 8'h04 | 8'(ps << 1));
         apb(1'b0, A_ST, 8'h00);
         wr(A_DT, 8'h07);
         poll(6);
         chk("tx parity", (ps == 1) ? 10'h20e : 10'h30e, node.got_word);
      end
      wr(A_C1, 8'h00);
      for (int lin = 0; lin < 2; lin++)
      begin
         wr(A_C3, 8'(lin << 6));
         node.last_low = 0;
         wr(A_C2, 8'h09);
         wr(A_C2, 8'h08);
         for (int k = 0; k < 600 && node.last_low == 0; k++) @(posedge pclk);
         chk("break len", (lin == 1) ? 10'd208 : 10'd160, 10'(node.last_low));
      end
      wr(A_C1, 8'h20);
      @(posedge pclk);
      chk("oe", 10'h0, 10'(tx_line_oe));
      wr(A_C1, 8'h00);
      @(posedge pclk);
      chk("oe", 10'h1, 10'(tx_line_oe));
      wr(A_C2, 8'h88);
      @(posedge pclk);
      chk("irq", 10'h1, 10'(irq_req));
      wr(A_C1, 8'h10);
      wr(A_C2, 8'h0c);
      node.send_frame(9'h1a5, 9);
      poll(5);
      rd(A_C1, 8'h80, 8'h80, "ninth");
      rd(A_DT, 8'hff, 8'ha5, "rx data");
      wr(A_C1, 8'h00);
      wr(A_C2, 8'h08);
      wr(A_C2, 8'h06);
      repeat (200) @(posedge pclk);
      rd(A_C2, 8'h02, 8'h00, "mute");
      rd(A_ST, 8'h10, 8'h00, "idle");
      finish_test();
   end
endmodule : async_serial_status_control_test
